/* File: shared/ccse_pkg.sv */
// constants and types of the card condition and fault register bank
package ccse_pkg;

  // *****************************
  // register map
  // *****************************
  localparam int         ADDR_W         = 8;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_FAULT     = 8'h08;
  localparam logic [7:0] ADDR_CONTROL   = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h14;
  localparam logic [7:0] ADDR_LOCATION  = 8'h18;

  // *****************************
  // field layout
  // *****************************
  localparam int MIRROR_LSB      = 20;
  localparam int BIT_SEEK        = 20;
  localparam int BIT_XFER_REQ    = 21;
  localparam int BIT_CORRECTED   = 22;
  localparam int BIT_CARD_FAULT  = 23;
  localparam int FAULT_W         = 8;
  localparam int FLT_RESET       = 0;
  localparam int FLT_READY       = 1;
  localparam int FLT_READ        = 2;
  localparam int FLT_WRITE       = 3;
  localparam int FLT_SECTOR      = 4;
  localparam int FLT_LOCATION    = 5;
  localparam int FLT_CHAIN       = 6;
  localparam int FLT_FETCH       = 7;
  localparam int CTRL_OVERRIDE   = 0;
  localparam int LOC_W           = 16;
  localparam int PIN_W           = 3;

  // *****************************
  // reset values and answers
  // *****************************
  localparam logic [31:0]      STATUS_RST   = 32'h0000_0000;
  localparam logic [7:0]       FAULT_RST    = 8'h00;
  localparam logic [31:0]      CONTROL_RST  = 32'h0000_0000;
  localparam logic [7:0]       MASK_RST     = 8'h00;
  localparam logic [LOC_W-1:0] LOCATION_RST = 16'h0000;
  localparam logic [1:0]       RESP_OKAY    = 2'h0;
  localparam logic [1:0]       RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic fault;
    logic corrected;
    logic xfer_req;
    logic seek_done;
  } ccse_card_flags_t;

  typedef struct packed {
    logic fetch_fault;
    logic chain_fail;
    logic location_check;
    logic sector_timeout;
    logic write_fail;
    logic read_fail;
    logic ready_timeout;
    logic reset_timeout;
  } ccse_fault_evt_t;

endpackage

/* File: verilog/ccse_regs.sv */
// card condition summary and fault detail register bank on an axi4-lite slave
//
// Behaviour
// - status bit 20 follows the card seek-complete flag every cycle.
// - status bit 21 follows the card data-request flag.
// - status bit 22 follows the card corrected-error flag.
// - status bit 23 follows the card error flag of the last command.
// - fault detail register answers at byte address 08h.
// - fault bit 0 sets on card reset time-out.
// - fault bit 1 sets on card ready time-out.
// - fault bit 2 sets on failed sector read or identify command.
// - fault bit 3 sets on failed sector write command.
// - fault bit 4 sets on sector valid time-out during read or write.
// - fault bit 5 sets when selected image location is not on the card.
// - fault bit 6 sets when programming the scan chain fails.
// - fault bit 7 sets on error while fetching configuration from the card.
`timescale 1ns/1ps
module ccse_regs
  import ccse_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire ccse_card_flags_t  card_flags,
  input  wire ccse_fault_evt_t   fault_evt,
  input  wire logic              op_start,
  input  wire logic [PIN_W-1:0]  location_pins,
  input  wire logic [LOC_W-1:0]  image_count,
  output logic                   location_source_override,
  output logic [LOC_W-1:0]       image_location_select,
  output logic                   irq
);

  // *****************************
  // helpers
  // *****************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    return a[ADDR_W-1:2] == r[ADDR_W-1:2];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // *****************************
  // state
  // *****************************
  logic              awready_reg;
  logic              aw_have_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic              wready_reg;
  logic              w_have_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       status_reg;
  logic [7:0]        fault_reg;
  logic [7:0]        fault_next;
  logic [31:0]       control_reg;
  logic [LOC_W-1:0]  location_reg;
  logic [7:0]        irq_stat_reg;
  logic [7:0]        irq_stat_next;
  logic [7:0]        mask_reg;
  logic              irq_reg;

  // *****************************
  // decode
  // *****************************
  wire              do_write   = aw_have_reg && w_have_reg && !bvalid_reg;
  wire              ar_hs      = s_axi_arvalid && arready_reg;
  wire              wr_control = do_write && hit(awaddr_reg, ADDR_CONTROL);
  wire              wr_mask    = do_write && hit(awaddr_reg, ADDR_IRQ_MASK);
  wire              wr_loc     = do_write && hit(awaddr_reg, ADDR_LOCATION);
  wire              wr_ok      = wr_control || wr_mask || wr_loc;
  wire              rd_clear   = ar_hs && hit(s_axi_araddr, ADDR_IRQ_STAT);
  wire              rd_known   = hit(s_axi_araddr, ADDR_STATUS) || hit(s_axi_araddr, ADDR_FAULT)
                                 || hit(s_axi_araddr, ADDR_CONTROL)
                                 || hit(s_axi_araddr, ADDR_IRQ_STAT)
                                 || hit(s_axi_araddr, ADDR_IRQ_MASK)
                                 || hit(s_axi_araddr, ADDR_LOCATION);
  wire [31:0]       rd_mux     =
      hit(s_axi_araddr, ADDR_STATUS)   ? status_reg :
      hit(s_axi_araddr, ADDR_FAULT)    ? {24'h00_0000, fault_reg} :
      hit(s_axi_araddr, ADDR_CONTROL)  ? control_reg :
      hit(s_axi_araddr, ADDR_IRQ_STAT) ? {24'h00_0000, irq_stat_reg} :
      hit(s_axi_araddr, ADDR_IRQ_MASK) ? {24'h00_0000, mask_reg} :
      hit(s_axi_araddr, ADDR_LOCATION) ? {16'h0000, location_reg} : 32'h0000_0000;
  wire [31:0]       ctrl_wr    = merge(control_reg, wdata_reg, wstrb_reg);
  wire [31:0]       loc_wr     = merge({16'h0000, location_reg}, wdata_reg, wstrb_reg);
  wire [31:0]       mask_wr    = merge({24'h00_0000, mask_reg}, wdata_reg, wstrb_reg);

  // selected image location: register when overridden, else the pins
  wire [LOC_W-1:0]  loc_sel    = control_reg[CTRL_OVERRIDE] ? location_reg
                                 : {{(LOC_W-PIN_W){1'b0}}, location_pins};
  wire              loc_bad    = loc_sel >= image_count;
  wire [7:0]        fault_set  = {fault_evt.fetch_fault, fault_evt.chain_fail,
                                  fault_evt.location_check && loc_bad,
                                  fault_evt.sector_timeout, fault_evt.write_fail,
                                  fault_evt.read_fail, fault_evt.ready_timeout,
                                  fault_evt.reset_timeout};
  wire [7:0]        fault_rise = fault_set & ~fault_reg;

  // *****************************
  // write channels
  // *****************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      aw_have_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
    end else if (s_axi_awvalid && awready_reg) begin
      awready_reg <= 1'b0;
      aw_have_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (bvalid_reg && s_axi_bready) begin
      awready_reg <= 1'b1;
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_reg <= 1'b1;
      w_have_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (s_axi_wvalid && wready_reg) begin
      wready_reg <= 1'b0;
      w_have_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (bvalid_reg && s_axi_bready) begin
      wready_reg <= 1'b1;
      w_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // *****************************
  // read channels
  // *****************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_mux;
      rresp_reg   <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // *****************************
  // software registers
  // *****************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_reg  <= CONTROL_RST;
      location_reg <= LOCATION_RST;
      mask_reg     <= MASK_RST;
    end else begin
      if (wr_control) control_reg <= ctrl_wr;
      if (wr_loc) location_reg <= loc_wr[LOC_W-1:0];
      if (wr_mask) mask_reg <= mask_wr[7:0];
    end
  end

  // *****************************
  // condition mirror and faults
  // *****************************
  // status is rebuilt from card_flags every cycle with a zero upper byte, so software never changes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= STATUS_RST;
    end else begin
      status_reg <= {8'h00, card_flags, 20'h0_0000};
    end
  end

  // a new event in the clearing cycle survives the clear
  assign fault_next    = (op_start ? FAULT_RST : fault_reg) | fault_set;
  assign irq_stat_next = (rd_clear ? 8'h00 : irq_stat_reg) | fault_rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_reg    <= FAULT_RST;
      irq_stat_reg <= 8'h00;
      irq_reg      <= 1'b0;
    end else begin
      fault_reg    <= fault_next;
      irq_stat_reg <= irq_stat_next;
      irq_reg      <= |(irq_stat_reg & mask_reg);
    end
  end

  // *****************************
  // outputs
  // *****************************
  assign s_axi_awready            = awready_reg;
  assign s_axi_wready             = wready_reg;
  assign s_axi_bvalid             = bvalid_reg;
  assign s_axi_bresp              = bresp_reg;
  assign s_axi_arready            = arready_reg;
  assign s_axi_rvalid             = rvalid_reg;
  assign s_axi_rdata              = rdata_reg;
  assign s_axi_rresp              = rresp_reg;
  assign location_source_override = control_reg[CTRL_OVERRIDE];
  assign image_location_select    = location_reg;
  assign irq                      = irq_reg;

  // *****************************
  // checks
  // *****************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_seek_mirror;
    1'b1 |=> (status_reg[BIT_SEEK] == $past(card_flags.seek_done));
  endproperty
  a_seek_mirror: assert property (p_seek_mirror) else $error("seek mirror wrong");

  property p_xfer_mirror;
    card_flags.xfer_req != status_reg[BIT_XFER_REQ]
      |=> status_reg[BIT_XFER_REQ] != $past(status_reg[BIT_XFER_REQ]);
  endproperty
  a_xfer_mirror: assert property (p_xfer_mirror) else $error("request mirror stuck");

  property p_corr_mirror;
    card_flags.corrected ##1 card_flags.corrected |-> status_reg[BIT_CORRECTED];
  endproperty
  a_corr_mirror: assert property (p_corr_mirror) else $error("corrected mirror wrong");

  property p_fault_mirror;
    !card_flags.fault |=> !status_reg[BIT_CARD_FAULT];
  endproperty
  a_fault_mirror: assert property (p_fault_mirror) else $error("card error mirror wrong");

  sequence s_fault_read;
    ar_hs && hit(s_axi_araddr, ADDR_FAULT);
  endsequence
  sequence s_fault_answer;
    s_axi_rvalid && s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h00_0000;
  endsequence
  property p_fault_read;
    s_fault_read |=> s_fault_answer ##0 (s_axi_rdata[7:0] == $past(fault_reg));
  endproperty
  a_fault_read: assert property (p_fault_read) else $error("fault read wrong");

  property p_reset_to;
    fault_evt.reset_timeout |=> fault_reg[FLT_RESET];
  endproperty
  a_reset_to: assert property (p_reset_to) else $error("reset time-out lost");

  property p_ready_to;
    fault_evt.ready_timeout |=> fault_reg[FLT_READY];
  endproperty
  a_ready_to: assert property (p_ready_to) else $error("ready time-out lost");

  property p_read_fail;
    fault_evt.read_fail |=> fault_reg[FLT_READ];
  endproperty
  a_read_fail: assert property (p_read_fail) else $error("read failure lost");

  property p_write_fail;
    fault_evt.write_fail |=> fault_reg[FLT_WRITE];
  endproperty
  a_write_fail: assert property (p_write_fail) else $error("write failure lost");

  property p_sector_to;
    fault_evt.sector_timeout |=> fault_reg[FLT_SECTOR];
  endproperty
  a_sector_to: assert property (p_sector_to) else $error("sector time-out lost");

  property p_location;
    fault_evt.location_check && !op_start
      |=> fault_reg[FLT_LOCATION] == $past(loc_bad || fault_reg[FLT_LOCATION]);
  endproperty
  a_location: assert property (p_location) else $error("location check wrong");

  property p_chain;
    fault_evt.chain_fail |=> fault_reg[FLT_CHAIN];
  endproperty
  a_chain: assert property (p_chain) else $error("chain failure lost");

  property p_fetch;
    fault_evt.fetch_fault |=> fault_reg[FLT_FETCH];
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch fault lost");

  property p_reserved;
    ar_hs && hit(s_axi_araddr, ADDR_STATUS) |=> s_axi_rvalid && s_axi_rdata[31:24] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bits set");

  property p_sticky;
    !op_start |=> (fault_reg & $past(fault_reg)) == $past(fault_reg);
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault bit dropped");

  property p_irq;
    (irq_stat_reg & mask_reg) != 8'h00 |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule

/* File: tb/ccse_card_model.sv */
// card-side model: card status flags, fault events and operation start
`timescale 1ns/1ps
module ccse_card_model
  import ccse_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] flags_req,
  input  wire logic [7:0] evt_req,
  input  wire logic       start_req,
  output ccse_card_flags_t card_flags,
  output ccse_fault_evt_t  fault_evt,
  output logic             op_start
);
  // *****************************
  // card side outputs
  // *****************************
  // flags are levels; events and start follow the request one edge later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      card_flags <= '0;
      fault_evt  <= '0;
      op_start   <= 1'b0;
    end else begin
      card_flags <= flags_req;
      fault_evt  <= evt_req;
      op_start   <= start_req;
    end
  end
endmodule

/* File: tb/ccse_regs_tb.sv */
// self-checking bench of the condition summary and fault detail register bank
`timescale 1ns/1ps
module ccse_regs_tb
  import ccse_pkg::*;
;
  // *****************************
  // signals
  // *****************************
  localparam int     LIMIT = 20000;
  logic              aclk, aresetn, start_req, op_start, irq, location_source_override;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb, flags_req;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [7:0]        evt_req;
  logic [PIN_W-1:0]  location_pins;
  logic [LOC_W-1:0]  image_count, image_location_select, loc, sel;
  logic              ovr;
  ccse_card_flags_t  card_flags;
  ccse_fault_evt_t   fault_evt;
  int                errors, n_tests, cyc;

  ccse_regs u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .card_flags, .fault_evt, .op_start, .location_pins,
    .image_count, .location_source_override, .image_location_select, .irq);

  ccse_card_model u_card (.aclk, .aresetn, .flags_req, .evt_req, .start_req, .card_flags,
    .fault_evt, .op_start);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // *****************************
  // helpers
  // *****************************
  task automatic stop_test();
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      $display("unexpected at %0t: run did not finish", $time);
      stop_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] exp_status(input logic [3:0] f);
    return 32'(f) << MIRROR_LSB;
  endfunction

  function automatic logic [31:0] exp_loc(input logic [LOC_W-1:0] s, input logic [LOC_W-1:0] c);
    return (s >= c) ? 32'h0000_0020 : 32'h0000_0000;
  endfunction

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                          input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata & m, e & m);
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic pulse(input logic [7:0] ev, input logic st);
    @(posedge aclk);
    evt_req <= ev;
    start_req <= st;
    @(posedge aclk);
    evt_req <= 8'h00;
    start_req <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  // *****************************
  // main sequence
  // *****************************
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, flags_req, evt_req, start_req} = '0;
    s_axi_wstrb = 4'hf;
    location_pins = '0;
    image_count = 16'hffff;
    errors = 0;
    n_tests = 0;
    cyc = 0;
    void'($urandom(37627));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(ADDR_STATUS, STATUS_RST, 32'hffff_ffff, RESP_OKAY);
    axi_read(ADDR_FAULT, 32'h0, 32'hffff_ffff, RESP_OKAY);
    axi_read(8'h1c, 32'h0, 32'hffff_ffff, RESP_SLVERR);
    for (int k = 0; k < 8; k++) begin
      flags_req <= (k < 4) ? 4'(1 << k) : 4'($urandom);
      repeat (4) @(posedge aclk);
      axi_read(ADDR_STATUS, exp_status(flags_req), 32'hffff_ffff, RESP_OKAY);
    end
    axi_write(ADDR_STATUS, 32'hffff_ffff, RESP_SLVERR);
    axi_read(ADDR_STATUS, exp_status(flags_req), 32'hffff_ffff, RESP_OKAY);
    for (int i = 0; i < FAULT_W; i++) begin
      if (i != FLT_LOCATION) begin
        pulse(8'h00, 1'b1);
        pulse(8'(1 << i), 1'b0);
        axi_read(ADDR_FAULT, 32'h1 << i, 32'hffff_ffff, RESP_OKAY);
        repeat (20) @(posedge aclk);
        axi_read(ADDR_FAULT, 32'h1 << i, 32'hffff_ffff, RESP_OKAY);
      end
    end
    axi_write(ADDR_FAULT, 32'h0, RESP_SLVERR);
    axi_read(ADDR_FAULT, 32'h80, 32'hffff_ffff, RESP_OKAY);
    pulse(8'h00, 1'b1);
    axi_read(ADDR_FAULT, 32'h0, 32'hffff_ffff, RESP_OKAY);
    pulse(8'h08, 1'b1);
    axi_read(ADDR_FAULT, 32'h08, 32'hffff_ffff, RESP_OKAY);
    for (int k = 0; k < 6; k++) begin
      ovr = 1'($urandom);
      loc = 16'($urandom);
      location_pins <= PIN_W'($urandom);
      axi_write(ADDR_CONTROL, {31'h0, ovr}, RESP_OKAY);
      axi_write(ADDR_LOCATION, {16'h0, loc}, RESP_OKAY);
      sel = ovr ? loc : LOC_W'(location_pins);
      image_count <= (k == 0) ? sel : (k == 1) ? sel + 16'h1 : 16'($urandom);
      check({31'h0, location_source_override}, {31'h0, ovr});
      check({16'h0, image_location_select}, {16'h0, loc});
      pulse(8'h00, 1'b1);
      pulse(8'h20, 1'b0);
      axi_read(ADDR_FAULT, exp_loc(sel, image_count), 32'hffff_ffff, RESP_OKAY);
    end
    s_axi_wstrb <= 4'h2;
    axi_write(ADDR_LOCATION, 32'hffff_ffff, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    axi_read(ADDR_LOCATION, {16'h0, 8'hff, loc[7:0]}, 32'hffff_ffff, RESP_OKAY);
    axi_write(ADDR_IRQ_MASK, 32'hff, RESP_OKAY);
    pulse(8'h00, 1'b1);
    check({31'h0, irq}, 32'h1);
    axi_read(ADDR_IRQ_STAT, 32'hff, 32'hffff_ffff, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    pulse(8'h04, 1'b0);
    check({31'h0, irq}, 32'h1);
    axi_read(ADDR_IRQ_STAT, 32'h04, 32'hff, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    axi_write(ADDR_IRQ_MASK, 32'h04, RESP_OKAY);
    pulse(8'h08, 1'b0);
    check({31'h0, irq}, 32'h0);
    axi_read(ADDR_IRQ_STAT, 32'h08, 32'hff, RESP_OKAY);
    axi_read(ADDR_IRQ_MASK, 32'h04, 32'hff, RESP_OKAY);
    stop_test();
  end
endmodule
